/* File: core/asa_regs.vh */
// Register map, field positions, reset values and timing figures of the serial adapter
`ifndef ASA_REGS_VH
`define ASA_REGS_VH

// Register slots, selected by the two slot select pins
`define ASA_SLOT_DATA 2'h0
`define ASA_SLOT_STATUS 2'h1
`define ASA_SLOT_COMMAND 2'h2
`define ASA_SLOT_CONTROL 2'h3

// Reset values
`define ASA_COMMAND_RST 8'h00
`define ASA_CONTROL_RST 8'h00
`define ASA_SOFT_CMD_KEEP 8'hE0

// Control fields
`define ASA_CTL_BAUD_LSB 0
`define ASA_CTL_BAUD_MSB 3
`define ASA_CTL_RXSRC 4
`define ASA_CTL_WLEN_LSB 5
`define ASA_CTL_WLEN_MSB 6
`define ASA_CTL_STOP2 7

// Command fields
`define ASA_CMD_TERM_EN 0
`define ASA_CMD_RXIRQ_DIS 1
`define ASA_CMD_TXC_LSB 2
`define ASA_CMD_TXC_MSB 3
`define ASA_CMD_PAR_EN 5
`define ASA_CMD_PAR_LSB 6
`define ASA_CMD_PAR_MSB 7

// Transmit control codes
`define ASA_TXC_OFF 2'h0
`define ASA_TXC_IRQ 2'h1

// Parity modes
`define ASA_PAR_ODD 2'h0
`define ASA_PAR_EVEN 2'h1
`define ASA_PAR_MARK 2'h2
`define ASA_PAR_SPACE 2'h3

// Status fields
`define ASA_ST_PARITY 0
`define ASA_ST_FRAME 1
`define ASA_ST_OVERRUN 2
`define ASA_ST_RXFULL 3
`define ASA_ST_TXEMPTY 4
`define ASA_ST_CARRIER 5
`define ASA_ST_SETRDY 6
`define ASA_ST_IRQ 7

// Timing: reference frequency and oversampling
`define ASA_REF_KHZ 1843.2
`define ASA_OVERSAMPLE 5'h10
`define ASA_MID_START 4'h7
`define ASA_MID_BIT 4'hF

// Reference edges per 16x tick, index 15 first; index 0 runs at the raw reference rate
`define ASA_BAUD_DIV_TABLE {12'h006, 12'h00C, 12'h010, 12'h018, 12'h020, 12'h030, 12'h040, \
	12'h060, 12'h0C0, 12'h180, 12'h300, 12'h359, 12'h417, 12'h600, 12'h900, 12'h001}

`endif

/* File: core/asa_top.v */
// Asynchronous serial adapter: host register port, baud generator, transmitter, receiver
// Function
// - Low hardware clear input clears internal registers
// - Host transfers timed by host phase clock
// - Direction line high reads, low writes
// - Interrupt output open drain, pulled low
// - Data lines driven only on selected reads
// - Selected when high select high, low select low
// - Four slots: data, status/reset, command, control
// - Reset slot write ignores data, clears low command bits, overrun and interrupt
// - Baud rates derived from reference oscillator pin
// - Serial output sends NRZ data LSB first
// - Receiver clocked by baud generator or pin
// - Receive clock pin outputs internal 16x clock
// - Send request output follows command register
// - Transmitter starts a character only while send clear low
// - Terminal ready low when command bit 0 set
// - Control bits 0-3 choose baud divisor
// - Status reports errors, full, empty, lines, interrupt
// - Transmit bit 0 first, unused high bits ignored
// - Received word LSB aligned, parity stripped, zeros
// - Nine-bit character: eight data plus parity
// - External receive clock divided by 16
// - Parity odd, even, none, mark, space
// - Word lengths 5 to 8, plus parity
`include "asa_regs.vh"

module asa_top #(
	parameter [191:0] BAUD_DIV_TABLE = `ASA_BAUD_DIV_TABLE
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Host bus
	input wire hw_clear_n,
	input wire phase_clk,
	input wire read_not_write,
	input wire select_high,
	input wire select_low_n,
	input wire slot_sel_lsb,
	input wire slot_sel_msb,
	input wire [7:0] host_data_bus_in,
	output reg [7:0] host_data_bus_out_q,
	output reg host_data_bus_oe_n_q,
	output reg irq_out_q,
	output reg irq_oe_n_q,
	// Reference oscillator
	input wire ref_osc_in,
	output reg ref_osc_out_q,
	// Serial lines
	output reg txd_q,
	input wire rxd,
	input wire rx_16x_clk_pin_in,
	output reg rx_16x_clk_pin_out_q,
	output reg rx_16x_clk_pin_oe_n_q,
	// Modem handshakes
	output reg send_req_n_q,
	output reg term_ready_n_q,
	input wire send_clear_n,
	input wire set_ready_n,
	input wire carrier_detect_n
);

	localparam NSYNC = 21;
	localparam [1:0] RX_IDLE = 2'h0;
	localparam [1:0] RX_START = 2'h1;
	localparam [1:0] RX_DATA = 2'h2;
	localparam [1:0] RX_STOP = 2'h3;

	reg [NSYNC-1:0] sync1_q;
	reg [NSYNC-1:0] sync2_q;
	reg phase_prev_q;
	reg ref_prev_q;
	reg rxc_prev_q;
	reg [7:0] command_q;
	reg [7:0] control_q;
	reg [7:0] rx_data_q;
	reg [7:0] tx_hold_q;
	reg parity_err_q;
	reg frame_err_q;
	reg overrun_q;
	reg rx_full_q;
	reg tx_empty_q;
	reg irq_q;
	reg carrier_prev_q;
	reg setrdy_prev_q;
	reg [11:0] baud_cnt_q;
	reg tick16_q;
	reg [11:0] tx_shift_q;
	reg [3:0] tx_bits_q;
	reg [3:0] tx_sub_q;
	reg tx_busy_q;
	reg [1:0] rx_state_q;
	reg [3:0] rx_sub_q;
	reg [3:0] rx_bits_q;
	reg [8:0] rx_shift_q;

	// Pin view after the synchroniser
	wire s_clear_n = sync2_q[0];
	wire s_phase = sync2_q[1];
	wire s_rw = sync2_q[2];
	wire s_sel_hi = sync2_q[3];
	wire s_sel_lo_n = sync2_q[4];
	wire [1:0] s_slot = sync2_q[6:5];
	wire [7:0] s_din = sync2_q[14:7];
	wire s_ref = sync2_q[15];
	wire s_rxd = sync2_q[16];
	wire s_rxc = sync2_q[17];
	wire s_clear_send_n = sync2_q[18];
	wire s_setrdy_n = sync2_q[19];
	wire s_carrier_n = sync2_q[20];

	// Bus decode; accesses take effect at the falling edge of the phase clock
	wire selected = s_sel_hi & ~s_sel_lo_n;
	wire access = phase_prev_q & ~s_phase & selected;
	wire wr = access & ~s_rw;
	wire rd = access & s_rw;
	wire hard_clear = rst | ~s_clear_n;

	// Frame format decode
	wire [1:0] wlen_code = control_q[`ASA_CTL_WLEN_MSB:`ASA_CTL_WLEN_LSB];
	wire [3:0] dlen = 4'h8 - {2'h0, wlen_code};
	wire [7:0] dmask = 8'hFF >> wlen_code;
	wire par_en = command_q[`ASA_CMD_PAR_EN];
	wire [1:0] par_mode = command_q[`ASA_CMD_PAR_MSB:`ASA_CMD_PAR_LSB];
	wire [3:0] stops = control_q[`ASA_CTL_STOP2] ? 4'h2 : 4'h1;
	wire [3:0] ndat = dlen + {3'h0, par_en};
	wire [1:0] txc = command_q[`ASA_CMD_TXC_MSB:`ASA_CMD_TXC_LSB];

	// Parity of a masked word for the selected mode
	function par_of;
		input [7:0] d;
		input [1:0] mode;
		begin
			case (mode)
				`ASA_PAR_ODD: par_of = ~^d;
				`ASA_PAR_EVEN: par_of = ^d;
				`ASA_PAR_MARK: par_of = 1'b1;
				default: par_of = 1'b0;
			endcase
		end
	endfunction

	// Transmit frame: start low, data LSB first, parity, stop bits, padded with mark
	wire [7:0] tx_word = tx_hold_q & dmask;
	wire tx_par = par_en & par_of(tx_word, par_mode);
	wire [11:0] tx_frame = (12'hFFF << (ndat + 4'h1)) | ({11'h000, tx_par} << (dlen + 4'h1))
		| {3'h0, tx_word, 1'b0};
	wire [3:0] tx_total = 4'h1 + ndat + stops;

	// Baud divisor for the selected rate
	wire [11:0] baud_div = BAUD_DIV_TABLE[control_q[`ASA_CTL_BAUD_MSB:`ASA_CTL_BAUD_LSB]*12 +: 12];
	wire ref_tick = s_ref & ~ref_prev_q;
	wire int_clk = control_q[`ASA_CTL_RXSRC];
	wire rx_tick = int_clk ? tick16_q : (s_rxc & ~rxc_prev_q);

	// Received word aligned to bit 0, parity taken from just above the data
	wire [8:0] rx_aligned = rx_shift_q >> (4'h9 - ndat);
	wire [7:0] rx_word = rx_aligned[7:0] & dmask;
	wire rx_par_bit = rx_aligned[dlen];
	wire rx_par_bad = par_en & (rx_par_bit != par_of(rx_word, par_mode));

	// Two-stage synchroniser for every pin input; stage one feeds stage two only
	always @(posedge clk) begin
		sync1_q <= {carrier_detect_n, set_ready_n, send_clear_n, rx_16x_clk_pin_in, rxd,
			ref_osc_in, host_data_bus_in, slot_sel_msb, slot_sel_lsb, select_low_n,
			select_high, read_not_write, phase_clk, hw_clear_n};
		sync2_q <= sync1_q;
	end

	// Edge history of the synchronised pins
	always @(posedge clk) begin
		if (rst) begin
			phase_prev_q <= 1'b0;
			ref_prev_q <= 1'b0;
			rxc_prev_q <= 1'b0;
		end else begin
			phase_prev_q <= s_phase;
			ref_prev_q <= s_ref;
			rxc_prev_q <= s_rxc;
		end
	end

	// Baud generator: counts reference edges, one 16x tick per divisor
	always @(posedge clk) begin
		if (hard_clear) begin
			baud_cnt_q <= 12'h000;
			tick16_q <= 1'b0;
		end else begin
			tick16_q <= 1'b0;
			if (ref_tick) begin
				if (baud_cnt_q >= baud_div - 12'h001) begin
					baud_cnt_q <= 12'h000;
					tick16_q <= 1'b1;
				end else begin
					baud_cnt_q <= baud_cnt_q + 12'h001;
				end
			end
		end
	end

	// Pin outputs: oscillator return, receive clock pin, handshakes
	always @(posedge clk) begin
		if (hard_clear) begin
			ref_osc_out_q <= 1'b1;
			rx_16x_clk_pin_out_q <= 1'b0;
			rx_16x_clk_pin_oe_n_q <= 1'b1;
			send_req_n_q <= 1'b1;
			term_ready_n_q <= 1'b1;
		end else begin
			ref_osc_out_q <= ~s_ref;
			// Square-ish wave: high for the first half of each divisor period;
			// a divisor of one has no count to split, so the synced reference goes out
			rx_16x_clk_pin_out_q <= (baud_div == 12'h001) ? s_ref
				: (baud_cnt_q < {1'b0, baud_div[11:1]});
			rx_16x_clk_pin_oe_n_q <= ~int_clk;
			send_req_n_q <= (txc == `ASA_TXC_OFF);
			term_ready_n_q <= ~command_q[`ASA_CMD_TERM_EN];
		end
	end

	// Host read data; driven only while a selected read phase is high
	always @(posedge clk) begin
		if (hard_clear) begin
			host_data_bus_out_q <= 8'h00;
			host_data_bus_oe_n_q <= 1'b1;
		end else begin
			host_data_bus_oe_n_q <= ~(s_phase & selected & s_rw);
			case (s_slot)
				`ASA_SLOT_DATA: host_data_bus_out_q <= rx_data_q;
				`ASA_SLOT_STATUS: host_data_bus_out_q <= {irq_q, s_setrdy_n, s_carrier_n,
					tx_empty_q, rx_full_q, overrun_q, frame_err_q, parity_err_q};
				`ASA_SLOT_COMMAND: host_data_bus_out_q <= command_q;
				default: host_data_bus_out_q <= control_q;
			endcase
		end
	end

	// Command and control registers; a reset-slot write clears the low command bits only
	always @(posedge clk) begin
		if (hard_clear) begin
			command_q <= `ASA_COMMAND_RST;
			control_q <= `ASA_CONTROL_RST;
		end else if (wr) begin
			case (s_slot)
				`ASA_SLOT_STATUS: command_q <= command_q & `ASA_SOFT_CMD_KEEP;
				`ASA_SLOT_COMMAND: command_q <= s_din;
				`ASA_SLOT_CONTROL: control_q <= s_din;
				default: command_q <= command_q;
			endcase
		end
	end

	// Transmitter; a new character starts only while send clear is low
	always @(posedge clk) begin
		if (hard_clear) begin
			tx_hold_q <= 8'h00;
			tx_empty_q <= 1'b1;
			tx_busy_q <= 1'b0;
			tx_shift_q <= 12'hFFF;
			tx_bits_q <= 4'h0;
			tx_sub_q <= 4'h0;
			txd_q <= 1'b1;
		end else begin
			if (tick16_q) begin
				if (tx_busy_q) begin
					tx_sub_q <= tx_sub_q + 4'h1;
					if (tx_sub_q == `ASA_MID_BIT) begin
						tx_shift_q <= {1'b1, tx_shift_q[11:1]};
						txd_q <= tx_shift_q[1];
						tx_bits_q <= tx_bits_q - 4'h1;
						if (tx_bits_q == 4'h1) begin
							tx_busy_q <= 1'b0;
							txd_q <= 1'b1;
						end
					end
				end else if (~tx_empty_q & ~s_clear_send_n) begin
					tx_shift_q <= tx_frame;
					txd_q <= 1'b0;
					tx_bits_q <= tx_total;
					tx_sub_q <= 4'h0;
					tx_busy_q <= 1'b1;
					tx_empty_q <= 1'b1;
				end
			end
			// A host write after the load in the same cycle still counts as new data
			if (wr && s_slot == `ASA_SLOT_DATA) begin
				tx_hold_q <= s_din;
				tx_empty_q <= 1'b0;
			end
		end
	end

	// Receiver sequencer on the selected 16x clock
	always @(posedge clk) begin
		if (hard_clear) begin
			rx_state_q <= RX_IDLE;
			rx_sub_q <= 4'h0;
			rx_bits_q <= 4'h0;
			rx_shift_q <= 9'h000;
		end else if (rx_tick) begin
			rx_sub_q <= rx_sub_q + 4'h1;
			case (rx_state_q)
				RX_IDLE: begin
					rx_sub_q <= 4'h0;
					if (~s_rxd) begin
						rx_state_q <= RX_START;
					end
				end
				RX_START: begin
					if (rx_sub_q == `ASA_MID_START) begin
						// A start that is gone by mid-bit was a glitch
						rx_state_q <= s_rxd ? RX_IDLE : RX_DATA;
						rx_sub_q <= 4'h0;
						rx_bits_q <= 4'h0;
					end
				end
				RX_DATA: begin
					if (rx_sub_q == `ASA_MID_BIT) begin
						rx_shift_q <= {s_rxd, rx_shift_q[8:1]};
						rx_bits_q <= rx_bits_q + 4'h1;
						if (rx_bits_q == ndat - 4'h1) begin
							rx_state_q <= RX_STOP;
						end
					end
				end
				default: begin
					if (rx_sub_q == `ASA_MID_BIT) begin
						rx_state_q <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// Receive data, status flags and interrupt; every hardware set wins over a clear
	wire rx_done = rx_tick & (rx_state_q == RX_STOP) & (rx_sub_q == `ASA_MID_BIT);
	wire rd_data = rd & (s_slot == `ASA_SLOT_DATA);
	wire rd_status = rd & (s_slot == `ASA_SLOT_STATUS);
	wire soft_reset = wr & (s_slot == `ASA_SLOT_STATUS);
	wire line_change = (carrier_prev_q != s_carrier_n) | (setrdy_prev_q != s_setrdy_n);
	wire rx_irq = ~command_q[`ASA_CMD_RXIRQ_DIS] & (rx_done | line_change);
	wire tx_irq = (txc == `ASA_TXC_IRQ) & tx_empty_q & ~tx_busy_q & tick16_q;
	wire irq_d = (irq_q & ~rd_status & ~soft_reset) | rx_irq | tx_irq;

	always @(posedge clk) begin
		if (hard_clear) begin
			rx_data_q <= 8'h00;
			rx_full_q <= 1'b0;
			parity_err_q <= 1'b0;
			frame_err_q <= 1'b0;
			overrun_q <= 1'b0;
			irq_q <= 1'b0;
			irq_out_q <= 1'b0;
			irq_oe_n_q <= 1'b1;
			// Track the pins through a clear so that no false change follows it
			carrier_prev_q <= s_carrier_n;
			setrdy_prev_q <= s_setrdy_n;
		end else begin
			carrier_prev_q <= s_carrier_n;
			setrdy_prev_q <= s_setrdy_n;
			if (rd_data) begin
				rx_full_q <= 1'b0;
				parity_err_q <= 1'b0;
				frame_err_q <= 1'b0;
				overrun_q <= 1'b0;
			end
			if (soft_reset) begin
				overrun_q <= 1'b0;
			end
			if (rx_done) begin
				if (rx_full_q & ~rd_data) begin
					// Unread data is kept; the new character is lost
					overrun_q <= 1'b1;
				end else begin
					rx_data_q <= rx_word;
					rx_full_q <= 1'b1;
					parity_err_q <= rx_par_bad;
					frame_err_q <= ~s_rxd;
				end
			end
			irq_q <= irq_d;
			irq_out_q <= 1'b0;
			irq_oe_n_q <= ~irq_d;
		end
	end

endmodule // asa_top

/* File: test/asa_chk.sv */
// Port checker for the serial adapter
module asa_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host side
	input wire logic hw_clear_n,
	input wire logic read_not_write,
	input wire logic select_high,
	input wire logic select_low_n,
	input wire logic host_data_bus_oe_n_q,
	input wire logic irq_out_q,
	input wire logic irq_oe_n_q,
	// Serial side
	input wire logic send_clear_n,
	input wire logic txd_q,
	input wire logic send_req_n_q,
	input wire logic term_ready_n_q,
	input wire logic rx_16x_clk_pin_oe_n_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [3:0] clr_q;
	logic [9:0] hi_q;
	logic [9:0] lo_q;
	// Level run lengths and time since a clear, saturating
	always_ff @(posedge clk) begin
		clr_q <= rst ? 4'hF : !hw_clear_n ? 4'h0 : clr_q + {3'h0, clr_q != 4'hF};
		hi_q <= (rst || !txd_q) ? 10'h000 : hi_q + {9'h000, hi_q != 10'h3FF};
		lo_q <= (rst || txd_q) ? 10'h000 : lo_q + {9'h000, lo_q != 10'h3FF};
	end
	sequence clear_held;
		!hw_clear_n [*4];
	endsequence
	// Long idle while the modem withholds clearance
	sequence quiet_cts;
		hi_q >= 10'd1000 && send_clear_n && $past(send_clear_n) && $past(send_clear_n, 2)
			&& $past(send_clear_n, 3);
	endsequence
	reset_outputs_a: assert property ($fell(rst) |-> txd_q && host_data_bus_oe_n_q
		&& irq_oe_n_q && term_ready_n_q && send_req_n_q && rx_16x_clk_pin_oe_n_q)
		else $error("outputs not idle after reset");
	hw_clear_a: assert property (clear_held |=> txd_q && term_ready_n_q
		&& host_data_bus_oe_n_q && irq_oe_n_q) else $error("clear pin ignored");
	bus_drive_a: assert property (!host_data_bus_oe_n_q |-> $past(read_not_write, 3)
		&& $past(select_high, 3) && !$past(select_low_n, 3)) else $error("bus driven wrongly");
	bus_hold_a: assert property ($fell(host_data_bus_oe_n_q) |->
		!host_data_bus_oe_n_q [*3]) else $error("read drive too short");
	irq_drain_a: assert property (!irq_oe_n_q |-> !irq_out_q)
		else $error("irq not open drain");
	pins_cause_a: assert property ($changed(term_ready_n_q) || $changed(send_req_n_q)
		|-> !$past(read_not_write, 3) || clr_q < 4'h8) else $error("modem pin moved alone");
	cts_block_a: assert property (quiet_cts |=> txd_q)
		else $error("start while not clear");
	bit_len_a: assert property ($rose(txd_q) |-> lo_q >= 10'd80)
		else $error("low bit too short");
endmodule // asa_chk

bind asa_top asa_chk asa_chk_i (.*);

/* File: test/asa_modem.sv */
// Modem and crystal stand-in facing the adapter's serial side
module asa_modem (
	// Reference and serial lines
	output logic ref_osc_in,
	output logic rxd,
	output logic rx_16x_clk_pin_in,
	// Modem status levels
	output logic set_ready_n,
	output logic carrier_detect_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ext_en = 1'b0;
	logic carrier_lvl = 1'b0;
	// Carrier level has a single driver; the bench changes carrier_lvl
	assign carrier_detect_n = carrier_lvl;
	// Near 1.8432 MHz, rounded to whole ns
	initial begin
		ref_osc_in = 1'b0;
		forever #271 ref_osc_in = ~ref_osc_in;
	end
	// 1 MHz external 16x clock, held still while not enabled
	initial begin
		rx_16x_clk_pin_in = 1'b0;
		forever #500 rx_16x_clk_pin_in = ext_en & ~rx_16x_clk_pin_in;
	end
	// Idle mark and steady levels, never left floating
	initial begin
		rxd = 1'b1;
		set_ready_n = 1'b0;
	end
	// Short low pulse on an idle line, well under half a bit
	task automatic glitch(input int t);
		#7 rxd = 1'b0;
		#t rxd = 1'b1;
	endtask
	// Start, n bits LSB first, one stop; offset keeps edges off the clock
	task automatic send(input logic [8:0] b, input int n, input int t);
		#7 rxd = 1'b0;
		#t;
		for (int i = 0; i < n; i++) begin
			rxd = b[i];
			#t;
		end
		rxd = 1'b1;
		#t;
	endtask
endmodule // asa_modem

/* File: test/testbench.sv */
// Self-checking bench: register port, transmit, receive, clears
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hw_clear_n = 1'b1;
	logic phase_clk = 1'b0;
	logic read_not_write = 1'b1;
	logic select_high = 1'b0;
	logic select_low_n = 1'b1;
	logic send_clear_n = 1'b0;
	logic [1:0] slot = 2'h0;
	logic [7:0] wdat = 8'h00;
	logic [7:0] rd;
	logic drv;
	int n_errors = 0;
	int total_checks = 0;
	wire [7:0] host_data_bus_out_q;
	wire host_data_bus_oe_n_q, irq_out_q, irq_oe_n_q, ref_osc_in, ref_osc_out_q, txd_q, rxd;
	wire rx_16x_clk_pin_in, rx_16x_clk_pin_out_q, rx_16x_clk_pin_oe_n_q;
	wire send_req_n_q, term_ready_n_q, set_ready_n, carrier_detect_n;
	asa_top asa_top_i (.clk, .rst, .hw_clear_n, .phase_clk, .read_not_write, .select_high,
		.select_low_n, .slot_sel_lsb(slot[0]), .slot_sel_msb(slot[1]), .host_data_bus_in(wdat),
		.host_data_bus_out_q, .host_data_bus_oe_n_q, .irq_out_q, .irq_oe_n_q, .ref_osc_in,
		.ref_osc_out_q, .txd_q, .rxd, .rx_16x_clk_pin_in, .rx_16x_clk_pin_out_q,
		.rx_16x_clk_pin_oe_n_q, .send_req_n_q, .term_ready_n_q, .send_clear_n, .set_ready_n,
		.carrier_detect_n);
	asa_modem asa_modem_i (.ref_osc_in, .rxd, .rx_16x_clk_pin_in, .set_ready_n,
		.carrier_detect_n);
	// 10 MHz system clock
	initial forever #50 clk = ~clk;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// One host access; phase held high six cycles, then low seven, pins steady beyond the commit
	task automatic bus(input logic rw, input logic [1:0] s, input logic [7:0] d, input logic cs);
		@(posedge clk);
		read_not_write <= rw;
		slot <= s;
		wdat <= d;
		select_high <= cs;
		select_low_n <= ~cs;
		repeat (5) @(posedge clk);
		phase_clk <= 1'b1;
		repeat (6) @(posedge clk);
		rd = host_data_bus_out_q;
		drv = ~host_data_bus_oe_n_q;
		phase_clk <= 1'b0;
		repeat (7) @(posedge clk);
		select_high <= 1'b0;
		select_low_n <= 1'b1;
	endtask
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		bus(1'b0, s, d, 1'b1);
	endtask
	task automatic rdx(input logic [1:0] s, input logic [7:0] m, input logic [7:0] e);
		bus(1'b1, s, 8'h00, 1'b1);
		check(rd & m, e, "read");
	endtask
	// Bounded wait for a start bit; a hang ends the run
	task automatic wait_low();
		int k = 0;
		while (txd_q !== 1'b0 && k < 4000) begin
			@(posedge clk);
			k++;
		end
		if (k == 4000) begin
			check(1'b1, 1'b0, "timeout");
			print_verdict();
		end
	endtask
	// One frame, each bit sampled near its middle
	task automatic tx(input logic [7:0] cm, ct, d, input int nb, input logic pb, hp);
		wr(2'h3, ct);
		wr(2'h2, cm);
		wr(2'h0, d);
		wait_low();
		repeat (43) @(posedge clk);
		check(txd_q, 1'b0, "start");
		for (int i = 0; i < nb + hp + 1; i++) begin
			repeat (87) @(posedge clk);
			check(txd_q, i < nb ? d[i] : (i == nb && hp ? pb : 1'b1), "bit");
		end
		repeat (200) @(posedge clk);
	endtask
	task automatic t_reset();
		check({term_ready_n_q, send_req_n_q, host_data_bus_oe_n_q, txd_q}, 8'h0F, "pins");
		rdx(2'h2, 8'hFF, 8'h00);
		rdx(2'h3, 8'hFF, 8'h00);
		rdx(2'h1, 8'h7F, 8'h10);
		$display("reset test done");
	endtask
	task automatic t_regs();
		wr(2'h2, 8'h09);
		check(drv, 1'b0, "write drive");
		check({term_ready_n_q, send_req_n_q}, 8'h00, "modem pins");
		rdx(2'h2, 8'hFF, 8'h09);
		check(drv, 1'b1, "read drive");
		bus(1'b0, 2'h3, 8'h5A, 1'b0);
		bus(1'b1, 2'h3, 8'h00, 1'b0);
		check(drv, 1'b0, "idle drive");
		rdx(2'h3, 8'hFF, 8'h00);
		asa_modem_i.carrier_lvl <= 1'b1;
		repeat (8) @(posedge clk);
		check(irq_oe_n_q, 1'b0, "irq pull");
		rdx(2'h1, 8'hE0, 8'hA0);
		repeat (5) @(posedge clk);
		check(irq_oe_n_q, 1'b1, "irq free");
		asa_modem_i.carrier_lvl <= 1'b0;
		repeat (8) @(posedge clk);
		rdx(2'h1, 8'h60, 8'h00);
		wr(2'h2, 8'h01);
		check(send_req_n_q, 1'b1, "send request");
		$display("register test done");
	endtask
	task automatic t_soft();
		wr(2'h2, 8'hE9);
		wr(2'h3, 8'h95);
		check(rx_16x_clk_pin_oe_n_q, 1'b0, "clock out");
		wr(2'h1, 8'hFF);
		rdx(2'h2, 8'hFF, 8'hE0);
		rdx(2'h3, 8'hFF, 8'h95);
		check(term_ready_n_q, 1'b1, "terminal");
		$display("soft reset test done");
	endtask
	task automatic t_tx();
		for (int m = 0; m < 4; m++) begin
			tx({m[1:0], 6'h29}, 8'h00, 8'hB4, 8, ~m[0], 1'b1);
		end
		tx(8'h29, 8'hE0, 8'hED, 5, 1'b0, 1'b1);
		$display("transmit test done");
	endtask
	// Held clearance blocks a start; releasing it lets the frame out
	task automatic t_cts();
		logic bad = 1'b0;
		send_clear_n <= 1'b1;
		repeat (1100) @(posedge clk);
		wr(2'h0, 8'h55);
		repeat (300) begin
			@(posedge clk);
			bad |= txd_q !== 1'b1;
		end
		check(bad, 1'b0, "blocked");
		send_clear_n <= 1'b0;
		wait_low();
		repeat (1000) @(posedge clk);
		$display("clear to send test done");
	endtask
	task automatic t_rx();
		int n_pin = 0;
		int n_ref = 0;
		logic p_pin;
		logic p_ref;
		wr(2'h3, 8'h10);
		wr(2'h2, 8'h29);
		// 542 cycles span 100 reference periods; index 0 runs at that rate
		p_pin = rx_16x_clk_pin_out_q;
		p_ref = ref_osc_out_q;
		repeat (542) begin
			@(posedge clk);
			n_pin += rx_16x_clk_pin_out_q & ~p_pin;
			n_ref += ref_osc_out_q & ~p_ref;
			p_pin = rx_16x_clk_pin_out_q;
			p_ref = ref_osc_out_q;
		end
		check(n_pin > 98 && n_pin < 102, 1'b1, "clock out rate");
		check(n_ref > 98 && n_ref < 102, 1'b1, "oscillator return");
		bus(1'b1, 2'h1, 8'h00, 1'b1);
		asa_modem_i.send(9'h13C, 9, 8672);
		repeat (20) @(posedge clk);
		check(irq_oe_n_q, 1'b0, "rx irq");
		rdx(2'h1, 8'h0F, 8'h08);
		rdx(2'h0, 8'hFF, 8'h3C);
		rdx(2'h1, 8'h08, 8'h00);
		asa_modem_i.glitch(1500);
		repeat (1000) @(posedge clk);
		rdx(2'h1, 8'h0F, 8'h00);
		wr(2'h3, 8'h20);
		wr(2'h2, 8'h09);
		check(rx_16x_clk_pin_oe_n_q, 1'b1, "clock in");
		asa_modem_i.ext_en = 1'b1;
		asa_modem_i.send(9'h0D5, 7, 16000);
		asa_modem_i.ext_en = 1'b0;
		repeat (20) @(posedge clk);
		rdx(2'h0, 8'hFF, 8'h55);
		rdx(2'h1, 8'h80, 8'h80);
		check(irq_oe_n_q, 1'b1, "irq cleared");
		wr(2'h2, 8'h07);
		repeat (20) @(posedge clk);
		check(irq_oe_n_q, 1'b0, "tx irq");
		$display("receive test done");
	endtask
	task automatic t_hwclr();
		wr(2'h2, 8'h09);
		hw_clear_n <= 1'b0;
		repeat (6) @(posedge clk);
		hw_clear_n <= 1'b1;
		repeat (5) @(posedge clk);
		check(term_ready_n_q, 1'b1, "clear pin");
		rdx(2'h2, 8'hFF, 8'h00);
		$display("clear pin test done");
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		t_regs();
		t_soft();
		t_tx();
		t_cts();
		t_rx();
		t_hwclr();
		print_verdict();
	end
endmodule // testbench
